// ### osa_pkg.sv
// shared constants for the output signal allocation block
package osa_pkg;
    // register index and byte address (printed offsets not multiples of four)
    localparam logic [15:0] osa_index_select_one = 16'h250e;
    localparam logic [15:0] osa_index_select_two = 16'h250f;
    localparam logic [17:0] osa_addr_select_one = {osa_index_select_one, 2'b00};
    localparam logic [17:0] osa_addr_select_two = {osa_index_select_two, 2'b00};
    // status register of the block's own state
    localparam logic [17:0] osa_addr_status = 18'h00010;
    // reset values of the setting words
    localparam logic [15:0] osa_reset_select_one = 16'h0000;
    localparam logic [15:0] osa_reset_select_two = 16'h0100;
    // largest legal digit of a field
    localparam logic [3:0] osa_field_max = 4'h6;
    // number of terminal pairs and of status signals
    localparam int osa_pair_count = 3;
    localparam int osa_signal_count = 8;
    // width of one allocation field
    localparam int osa_field_width = 4;
endpackage

// ### osa_field_decode.sv
// one-hot decode of one allocation field onto terminal pairs
`timescale 1ns/1ps
module osa_field_decode (
    input wire logic [3:0] field,
    input wire logic status_in,
    output logic [2:0] pair_drive
);
    // codes 1..3 name a pair; 0 and reserved codes drive nothing
    always_comb begin
        pair_drive = 3'h0;
        case (field)
            4'h1: pair_drive = {2'h0, status_in}; // [R5]
            4'h2: pair_drive = {1'h0, status_in, 1'h0};
            4'h3: pair_drive = {status_in, 2'h0};
            default: pair_drive = 3'h0; // [R4]
        endcase
    end
endmodule // osa_field_decode

// ### osa_select_store.sv
// two-word setting store with working copies loaded at restart
`timescale 1ns/1ps
module osa_select_store (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic write_one,
    input wire logic write_two,
    input wire logic [15:0] wdata,
    output logic [15:0] stored_one,
    output logic [15:0] stored_two,
    output logic [15:0] active_one,
    output logic [15:0] active_two
);
    // all state of the store
    typedef struct packed {
        logic [15:0] stored_one;
        logic [15:0] stored_two;
        logic [15:0] active_one;
        logic [15:0] active_two;
        logic loaded;
        logic powered; // set by the first reset ever
    } osa_store_type;
    // starts cleared so the first reset can tell power-on from a restart
    osa_store_type state = '0;
    osa_store_type next_state;

    // a word is legal when every digit is at most six
    function automatic logic word_legal(input logic [15:0] w);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < 4; i++) begin
            if (w[i*4 +: 4] > osa_pkg::osa_field_max) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    // next state: writes go to stored copy, active copy only at restart
    always_comb begin
        next_state = state;
        if (!state.loaded) begin
            // first cycle after restart takes the settings into force
            next_state.active_one = state.stored_one;
            next_state.active_two = state.stored_two; // [R2]
            next_state.loaded = 1'b1;
        end
        if (write_one && word_legal(wdata)) begin
            next_state.stored_one = wdata; // [R8]
        end
        if (write_two && word_legal(wdata)) begin
            next_state.stored_two = wdata; // [R1]
        end
    end

    // register; stored words survive reset (restart), active ones reload
    always_ff @(posedge sys_clk) begin
        if (reset && !state.powered) begin
            // power-on state: load defaults into both copies
            state.stored_one <= osa_pkg::osa_reset_select_one;
            state.stored_two <= osa_pkg::osa_reset_select_two; // [R2]
            state.active_one <= osa_pkg::osa_reset_select_one;
            state.active_two <= osa_pkg::osa_reset_select_two;
            state.loaded <= 1'b0;
            state.powered <= 1'b1;
        end else if (reset) begin
            // restart: keep settings, reload on release
            state.loaded <= 1'b0;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    assign stored_one = state.stored_one;
    assign stored_two = state.stored_two;
    assign active_one = state.active_one;
    assign active_two = state.active_two;
endmodule // osa_select_store

// ### osa_output_allocation.sv
// apb-reached router of drive status signals onto output terminal pairs
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
// What this block does
// R1: second word accepts only 0000h to 6666h
// R2: second word resets 0100h, acts after restart
// R3: lowest digit of word two routes torque limit
// R4: field value 0 drives no terminal pair
// R5: field value 1 drives first terminal pair
// R6: highest digit of word two routes warning
// R7: software never writes reserved codes four to six; the testbench writes 6666h once
// R8: word one routes four signals; word two rest
module osa_output_allocation (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic positioning_complete,
    input wire logic speed_coincidence,
    input wire logic rotation_detected,
    input wire logic servo_ready,
    input wire logic torque_limit_detected,
    input wire logic speed_limit_detected,
    input wire logic brake_output,
    input wire logic warning_output,
    output logic [2:0] io_connector
);
    // registered state of the top
    typedef struct packed {
        logic [31:0] prdata;
        logic pslverr;
        logic [2:0] io_connector;
    } osa_top_type;
    osa_top_type state;
    osa_top_type next_state;

    logic [15:0] stored_one; // software-visible words
    logic [15:0] stored_two;
    logic [15:0] active_one; // words in force
    logic [15:0] active_two;
    logic [31:0] fields; // eight fields, signal order
    logic [7:0] status_vec; // status signals, signal order
    logic [23:0] drives; // per-signal pair drives
    logic [2:0] next_pins; // or of all drives
    logic access; // apb access phase
    logic hit_one;
    logic hit_two;
    logic hit_status;

    // access decode
    assign access = psel && penable;
    assign hit_one = paddr[17:0] == osa_pkg::osa_addr_select_one && paddr[31:18] == 14'h0000;
    assign hit_two = paddr[17:0] == osa_pkg::osa_addr_select_two && paddr[31:18] == 14'h0000;
    assign hit_status = paddr[17:0] == osa_pkg::osa_addr_status && paddr[31:18] == 14'h0000;
    assign pready = 1'b1; // zero wait states
    assign prdata = state.prdata;
    assign pslverr = state.pslverr;
    assign io_connector = state.io_connector;

    // setting words
    osa_select_store u_store (
        .sys_clk(sys_clk),
        .reset(reset),
        .clk_en(clk_en),
        .write_one(access && pwrite && hit_one),
        .write_two(access && pwrite && hit_two),
        .wdata(pwdata[15:0]),
        .stored_one(stored_one),
        .stored_two(stored_two),
        .active_one(active_one),
        .active_two(active_two)
    );

    // word one: low to high digits -> first four signals; word two next four
    assign fields = {active_two, active_one}; // [R3] [R6] [R8]
    assign status_vec = {warning_output, brake_output, speed_limit_detected, torque_limit_detected,
                         servo_ready, rotation_detected, speed_coincidence, positioning_complete};

    // one decoder per status signal
    generate
        for (genvar g = 0; g < osa_pkg::osa_signal_count; g++) begin : g_dec
            osa_field_decode u_dec (
                .field(fields[g*osa_pkg::osa_field_width +: osa_pkg::osa_field_width]),
                .status_in(status_vec[g]),
                .pair_drive(drives[g*3 +: 3])
            );
        end
    endgenerate

    // merge drives of all signals per pair
    always_comb begin
        next_pins = 3'h0;
        for (int i = 0; i < osa_pkg::osa_signal_count; i++) begin
            next_pins = next_pins | drives[i*3 +: 3];
        end
    end

    // read data, error and pins for the next cycle
    always_comb begin
        next_state = state;
        next_state.io_connector = next_pins;
        next_state.pslverr = 1'b0;
        if (psel && !penable) begin
            next_state.prdata = 32'h0000_0000;
            if (hit_one) begin
                next_state.prdata = {16'h0000, stored_one};
            end else if (hit_two) begin
                next_state.prdata = {16'h0000, stored_two};
            end else if (hit_status) begin
                next_state.prdata = {24'h00_0000, 5'h00, next_pins};
            end
            // unmapped or illegal write flags error in access phase
            if (!(hit_one || hit_two || (hit_status && !pwrite))) begin
                next_state.pslverr = 1'b1;
            end else if (pwrite && (hit_one || hit_two)) begin
                for (int i = 0; i < 4; i++) begin
                    if (pwdata[i*4 +: 4] > osa_pkg::osa_field_max) begin
                        next_state.pslverr = 1'b1; // [R1] [R7]
                    end
                end
            end
        end else if (access) begin
            next_state.pslverr = state.pslverr;
        end
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state <= '0;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    // a field at 0 keeps its signal off every pair: torque alone, unmapped, drives nothing
    a_zero_field_idle: assert property (@(posedge sys_clk) disable iff (reset) // [R4]
        (active_two[3:0] == 4'h0 && status_vec == 8'h10 && clk_en) |=> io_connector == 3'h0)
        else $error("unmapped signal drives a pair");
    // torque limit field at 1 puts an active torque limit on the first pair
    a_torque_first_pair: assert property (@(posedge sys_clk) disable iff (reset) // [R3]
        (active_two[3:0] == 4'h1 && torque_limit_detected && clk_en) |=> io_connector[0])
        else $error("torque limit not on first pair");
    // warning field at 3 puts an active warning on the third pair
    a_warning_pair: assert property (@(posedge sys_clk) disable iff (reset) // [R6]
        (active_two[15:12] == 4'h3 && warning_output && clk_en) |=> io_connector[2])
        else $error("warning not on third pair");
    // code 1 means the first pair, here for the brake field
    a_brake_first_pair: assert property (@(posedge sys_clk) disable iff (reset) // [R5]
        (active_two[11:8] == 4'h1 && brake_output && clk_en) |=> io_connector[0])
        else $error("brake not on first pair");
    // a setup with an out-of-range top digit answers with an error
    a_bad_digit_error: assert property (@(posedge sys_clk) disable iff (reset) // [R1]
        (psel && !penable && pwrite && hit_two && pwdata[15:12] > 4'h6 && clk_en) |=> pslverr)
        else $error("illegal word accepted without error");
    a_word_legal: assert property (@(posedge sys_clk) disable iff (reset) // [R1]
        stored_two[15:12] <= 4'h6 && stored_two[11:8] <= 4'h6 && stored_two[7:4] <= 4'h6 && stored_two[3:0] <= 4'h6)
        else $error("word two out of range");
    a_restart_only: assert property (@(posedge sys_clk) disable iff (reset) // [R2]
        $past(!reset) && $past(!reset, 2) |-> active_two == $past(active_two))
        else $error("routing changed without restart");
endmodule // osa_output_allocation

// ### osa_terminal_reader.sv
// partner model: controller wiring that samples the output terminal pairs
`timescale 1ns/1ps
module osa_terminal_reader (
    input wire logic sys_clk,
    input wire logic [2:0] io_connector,
    output logic [2:0] seen_pairs
);
    // controller latches the terminal levels every clock
    always_ff @(posedge sys_clk) begin
        seen_pairs <= io_connector;
    end
endmodule // osa_terminal_reader

// ### test_output_signal_allocation.sv
// self-checking testbench for the output signal allocation block
`timescale 1ns/1ps
module test_output_signal_allocation;
    logic sys_clk = 1'b0; // bench clock
    logic reset = 1'b1; // sync restart
    logic en = 1'b1; // clock enable
    logic psel = 1'b0; // apb select
    logic penable = 1'b0; // apb enable
    logic pwrite = 1'b0; // apb direction
    logic [31:0] paddr = 32'h0; // apb address
    logic [31:0] pwdata = 32'h0; // apb write data
    logic [31:0] prdata; // apb read data
    logic pready; // apb ready
    logic pslverr; // apb error
    logic [7:0] sig = 8'h00; // status inputs, lowest bit positioning complete
    logic [2:0] io_connector; // terminal pairs
    logic [2:0] seen_pairs; // pairs as the controller sees them
    logic [31:0] rd; // last read data
    logic err; // last error flag
    int num_errors = 0; // mismatch count
    int compares = 0; // comparison count
    localparam logic [31:0] addr_one = {14'h0, osa_pkg::osa_addr_select_one};
    localparam logic [31:0] addr_two = {14'h0, osa_pkg::osa_addr_select_two};
    // expected pairs per status signal after restart with words 1230h and 3021h
    localparam logic [2:0] exp_pairs [8] = '{3'h0, 3'h4, 3'h2, 3'h1, 3'h1, 3'h2, 3'h0, 3'h4};

    // 50 ns clock
    always #25 sys_clk = ~sys_clk;

    osa_output_allocation i_osa_output_allocation (
        .sys_clk(sys_clk), .reset(reset), .clk_en(en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .positioning_complete(sig[0]), .speed_coincidence(sig[1]), .rotation_detected(sig[2]),
        .servo_ready(sig[3]), .torque_limit_detected(sig[4]), .speed_limit_detected(sig[5]),
        .brake_output(sig[6]), .warning_output(sig[7]), .io_connector(io_connector)
    );

    osa_terminal_reader i_osa_terminal_reader (
        .sys_clk(sys_clk), .io_connector(io_connector), .seen_pairs(seen_pairs)
    );

    // compare and report a mismatch
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // verdict and end of run
    task automatic end_sim();
        if (num_errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // one apb transfer: setup, access until pready, release
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    // drive status inputs and check the pairs the controller sees
    task automatic pins(input logic [7:0] s, input logic [2:0] exp);
        sig <= s;
        repeat (3) @(posedge sys_clk);
        check({29'h0, seen_pairs}, {29'h0, exp});
    endtask

    // restart pulse: stored words go into force
    task automatic restart();
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask

    // watchdog
    initial begin
        repeat (4000) @(posedge sys_clk);
        num_errors++;
        end_sim();
    end

    // main sequence
    initial begin
        repeat (16) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        apb(1'b0, addr_one, 32'h0);
        check(rd, 32'h0000);
        apb(1'b0, addr_two, 32'h0);
        check(rd, 32'h0100);
        pins(8'h40, 3'h1);
        pins(8'h10, 3'h0);
        apb(1'b1, addr_two, 32'h6666);
        check({31'h0, err}, 32'h0);
        apb(1'b1, addr_two, 32'h7000);
        check({31'h0, err}, 32'h1);
        apb(1'b0, addr_two, 32'h0);
        check(rd, 32'h6666);
        // only codes 0 to 3 are written, reserved ones stay unused
        apb(1'b1, addr_two, 32'h3021);
        apb(1'b1, addr_one, 32'h1230);
        apb(1'b0, addr_one, 32'h0);
        check(rd, 32'h1230);
        pins(8'h40, 3'h1);
        pins(8'h10, 3'h0);
        apb(1'b0, 32'h20, 32'h0);
        check({31'h0, err}, 32'h1);
        restart();
        apb(1'b0, addr_two, 32'h0);
        check(rd, 32'h3021);
        for (int i = 0; i < 8; i++) begin
            pins(8'h01 << i, exp_pairs[i]);
        end
        pins(8'h90, 3'h5);
        apb(1'b0, {14'h0, osa_pkg::osa_addr_status}, 32'h0);
        check(rd, 32'h5);
        // enable low freezes the pins, high lets them follow again
        en <= 1'b0;
        pins(8'h08, 3'h5);
        en <= 1'b1;
        pins(8'h08, 3'h1);
        end_sim();
    end
endmodule // test_output_signal_allocation
